// *** logic/gsim_pkg.sv ***
// Constants for the shared interrupt mask, route and inter-processor trigger block.
// Assumes a 32-bit register bus with byte addresses held in the low 16 bits.
package gsim_pkg;

   // Build-time size of the controller
   localparam int MAX_SRC = 256;
   localparam int SRC_COUNT = 64;
   localparam int NUM_VP = 24;
   localparam int VP_PER_CORE = 4;
   localparam int PIN_W = 6;
   localparam int ADDR_W = 16;

   // Register byte offsets
   localparam logic [15:0] CFG_OFS = 16'h0000;
   localparam logic [15:0] WEDGE_OFS = 16'h0280;
   localparam logic [15:0] DISABLE_BASE = 16'h0300;
   localparam logic [15:0] ENSET_BASE = 16'h0380;
   localparam logic [15:0] ENSTATE_BASE = 16'h0400;
   localparam logic [15:0] PEND_BASE = 16'h0480;
   localparam logic [15:0] PINMAP_BASE = 16'h0500;
   localparam logic [15:0] PINMAP_LAST = 16'h08FC;
   localparam logic [15:0] VPMAP_BASE = 16'h2000;
   localparam logic [15:0] VPMAP_LAST = 16'h3FE0;
   localparam logic [15:0] VPCTL_BASE = 16'h4000;
   localparam logic [15:0] VPCTL_LAST = 16'h405C;

   // Field positions
   localparam int PIN_ORDINARY_BIT = 31;
   localparam int WEDGE_RAISE_BIT = 31;
   localparam int WEDGE_NUM_MSB = 7;
   localparam int CTL_EIC_BIT = 0;
   localparam int CFG_COUNT_MSB = 8;

   // Reset values
   localparam logic RST_ENABLE = 1'b0;
   localparam logic RST_PEND = 1'b0;
   localparam logic RST_ORDINARY = 1'b0;
   localparam logic [PIN_W-1:0] RST_PINMAP = 6'h00;
   localparam logic [NUM_VP-1:0] RST_VPMAP = 24'h00_0000;
   localparam logic RST_EIC = 1'b0;

   // Highest deliverable level in controller mode
   localparam logic [PIN_W:0] EIC_LEVEL_MAX = 7'h3F;

   typedef enum logic [1:0]
   {
      SL_IDLE = 2'b00,
      SL_RDWAIT = 2'b01,
      SL_RDDONE = 2'b10
   } gsim_slave_state_t;

endpackage

// *** logic/gsim_reg_if.sv ***
// Register access carrier between the bus slave and the controller core.
// Write strobe and data stand for one cycle; read data is looked up combinationally.
`timescale 1ns/100ps
interface gsim_reg_if;
   import gsim_pkg::*;

   logic wrEn;
   logic [ADDR_W-1:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;

   modport slave
   (
      output wrEn,
      output addr,
      output wdata,
      input rdata
   );

   modport core
   (
      input wrEn,
      input addr,
      input wdata,
      output rdata
   );
endinterface

// *** logic/gsim_ahb_slave.sv ***
// AHB-Lite slave front end: zero-wait writes, one wait state on reads.
// Assumes one master and single word transfers; response is always OKAY.
`timescale 1ns/100ps
module gsim_ahb_slave
   import gsim_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // AHB-Lite
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Core side
   gsim_reg_if.slave regs
);

   gsim_slave_state_t state_reg;
   gsim_slave_state_t state_next;
   logic wrPhase_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [31:0] hrdata_reg;
   wire addrPhase;
   wire startRead;

   assign addrPhase = hsel && htrans[1] && hready;
   assign startRead = addrPhase && !hwrite;

   // Read data is fetched one cycle into the data phase so a write that ends
   // just before is already visible
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         SL_IDLE: state_next = startRead ? SL_RDWAIT : SL_IDLE;
         SL_RDWAIT: state_next = SL_RDDONE;
         SL_RDDONE: state_next = startRead ? SL_RDWAIT : SL_IDLE;
         default: state_next = SL_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state_reg <= SL_IDLE;
         wrPhase_reg <= 1'b0;
         addr_reg <= 16'h0000;
         hrdata_reg <= 32'h0000_0000;
      end
      else
      begin
         state_reg <= state_next;
         wrPhase_reg <= addrPhase && hwrite;
         if (addrPhase)
            addr_reg <= haddr[ADDR_W-1:0];
         if (state_reg == SL_RDWAIT)
            hrdata_reg <= regs.rdata;
      end
   end

   assign regs.wrEn = wrPhase_reg;
   assign regs.addr = addr_reg;
   assign regs.wdata = hwdata;
   assign hreadyout = (state_reg != SL_RDWAIT);
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;

endmodule

// *** logic/gsim_vp_route.sv ***
// Per-target output stage: folds every source routed to one target, bar pin-mode ones mapped past pin 5, into its
// six interrupt lines and its non-maskable line, both registered.
`timescale 1ns/100ps
module gsim_vp_route
   import gsim_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Routing inputs
   input wire logic eicMode,
   input wire logic [SRC_COUNT-1:0] active,
   input wire logic [SRC_COUNT-1:0] ordinary,
   input wire logic [SRC_COUNT-1:0][PIN_W-1:0] pinMap,
   // Target outputs
   output logic [PIN_W-1:0] intrOut,
   output logic nmiOut
);

   logic [PIN_W-1:0] pins_next;
   logic nmi_next;
   logic [PIN_W:0] level;
   logic [PIN_W:0] cand;

   always_comb
   begin
      pins_next = 6'h00;
      nmi_next = 1'b0;
      level = 7'h00;
      cand = 7'h00;
      for (int s = 0; s < SRC_COUNT; s++)
      begin
         cand = {1'b0, pinMap[s]} + 7'h01;
         if (cand > EIC_LEVEL_MAX)
            cand = EIC_LEVEL_MAX;
         if (active[s])
         begin
            if (!ordinary[s])
               nmi_next = 1'b1;
            else if (eicMode)
            begin
               // Highest level wins; zero is left for nothing pending
               if (cand > level)
                  level = cand;
            end
            else if (pinMap[s] < 6'(PIN_W))
               pins_next[pinMap[s][2:0]] = 1'b1;
         end
      end
      if (eicMode)
         pins_next = level[PIN_W-1:0];
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         intrOut <= 6'h00;
         nmiOut <= 1'b0;
      end
      else
      begin
         intrOut <= pins_next;
         nmiOut <= nmi_next;
      end
   end

endmodule

// *** logic/gsim_shared_irq.sv ***
// Shared section of the global interrupt controller: source enables, pending
// flags, per-source routing maps, per-target mode and the software edge trigger.
// Assumes source inputs are synchronous to clk_sys and rise to signal an event.
`timescale 1ns/100ps

module gsim_shared_irq
   import gsim_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // AHB-Lite register port
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Interrupt sources
   input wire logic [SRC_COUNT-1:0] srcIn,
   // Target outputs, index is four times core plus target within core
   output logic [NUM_VP-1:0][PIN_W-1:0] vpIntr,
   output logic [NUM_VP-1:0] vpNmi
);

   gsim_reg_if regBus ();

   // Source state
   logic [SRC_COUNT-1:0] enableReg;
   logic [SRC_COUNT-1:0] enableNext;
   logic [SRC_COUNT-1:0] pendReg;
   logic [SRC_COUNT-1:0] pendNext;
   logic [SRC_COUNT-1:0] srcPrev_reg;
   logic [SRC_COUNT-1:0] ordinaryReg;
   logic [SRC_COUNT-1:0][PIN_W-1:0] pinMapReg;
   logic [SRC_COUNT-1:0][NUM_VP-1:0] vpMapReg;
   logic [NUM_VP-1:0] eicReg;

   // Address decode
   wire [ADDR_W-1:0] addr;
   wire wr;
   wire aligned;
   wire setSel;
   wire disableSel;
   wire stateSel;
   wire pendSel;
   wire wedgeSel;
   wire pinSel;
   wire vpSel;
   wire ctlSel;
   wire [ADDR_W-1:0] pinOff;
   wire [ADDR_W-1:0] vpOff;
   wire [ADDR_W-1:0] ctlOff;
   wire [7:0] pinIdx;
   wire [7:0] vpIdx;
   wire [4:0] ctlIdx;
   wire pinImpl;
   wire vpImpl;
   wire [7:0] laneShift;
   wire [MAX_SRC-1:0] laneData;
   wire [MAX_SRC-1:0] enWide;
   wire [MAX_SRC-1:0] pendWide;

   // Software edge trigger fields
   wire [WEDGE_NUM_MSB:0] wedgeNum;
   wire wedgeRaise;
   wire wedgeOk;
   wire [31:0] cfgWord;

   gsim_ahb_slave u_slave
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .regs(regBus.slave)
   );

   assign addr = regBus.addr;
   assign wr = regBus.wrEn;
   assign aligned = (addr[1:0] == 2'b00);

   // Each register spans 0x20 bytes: eight words covering up to 256 sources
   assign setSel = aligned && (addr[15:5] == ENSET_BASE[15:5]);
   assign disableSel = aligned && (addr[15:5] == DISABLE_BASE[15:5]);
   assign stateSel = aligned && (addr[15:5] == ENSTATE_BASE[15:5]);
   assign pendSel = aligned && (addr[15:5] == PEND_BASE[15:5]);
   assign wedgeSel = (addr == WEDGE_OFS);
   assign pinSel = aligned && (addr >= PINMAP_BASE) && (addr <= PINMAP_LAST);
   assign vpSel = (addr >= VPMAP_BASE) && (addr <= VPMAP_LAST) && (vpOff[4:0] == 5'h00);
   assign ctlSel = aligned && (addr >= VPCTL_BASE) && (addr <= VPCTL_LAST);

   assign pinOff = addr - PINMAP_BASE;
   assign vpOff = addr - VPMAP_BASE;
   assign ctlOff = addr - VPCTL_BASE;
   assign pinIdx = pinOff[9:2];
   assign vpIdx = vpOff[12:5];
   assign ctlIdx = ctlOff[6:2];
   assign pinImpl = ({1'b0, pinIdx} < 9'(SRC_COUNT));
   assign vpImpl = ({1'b0, vpIdx} < 9'(SRC_COUNT));

   // Word k of a group covers sources 32k to 32k+31
   assign laneShift = {addr[4:2], 5'b00000};
   assign laneData = {{(MAX_SRC-32){1'b0}}, regBus.wdata} << laneShift;
   assign enWide = {{(MAX_SRC-SRC_COUNT){1'b0}}, enableReg};
   assign pendWide = {{(MAX_SRC-SRC_COUNT){1'b0}}, pendReg};

   assign wedgeNum = regBus.wdata[WEDGE_NUM_MSB:0];
   assign wedgeRaise = regBus.wdata[WEDGE_RAISE_BIT];
   // Numbers past the implemented sources are dropped
   assign wedgeOk = wr && wedgeSel && ({1'b0, wedgeNum} < 9'(SRC_COUNT));

   assign cfgWord = {23'h00_0000, 9'(SRC_COUNT)};

   // Per-source enable, pending and routing state
   genvar s;
   generate
      for (s = 0; s < SRC_COUNT; s++)
      begin : g_src
         wire setBit;
         wire clrBit;
         wire edgeSet;
         wire edgeClr;
         wire hwEvent;
         wire pinWr;
         wire vpWr;

         assign setBit = wr && setSel && laneData[s];
         assign clrBit = wr && disableSel && laneData[s];
         assign edgeSet = wedgeOk && wedgeRaise && (wedgeNum == 8'(s));
         assign edgeClr = wedgeOk && !wedgeRaise && (wedgeNum == 8'(s));
         assign hwEvent = srcIn[s] && !srcPrev_reg[s];
         assign pinWr = wr && pinSel && (pinIdx == 8'(s));
         assign vpWr = wr && vpSel && (vpIdx == 8'(s));

         assign enableNext[s] = setBit || (enableReg[s] && !clrBit);
         // A new event in the clearing cycle keeps the flag set
         assign pendNext[s] = hwEvent || edgeSet || (pendReg[s] && !edgeClr);

         always_ff @(posedge clk_sys)
         begin
            if (rst)
            begin
               enableReg[s] <= RST_ENABLE;
               pendReg[s] <= RST_PEND;
               srcPrev_reg[s] <= 1'b0;
            end
            else
            begin
               enableReg[s] <= enableNext[s];
               pendReg[s] <= pendNext[s];
               srcPrev_reg[s] <= srcIn[s];
            end
         end

         always_ff @(posedge clk_sys)
         begin
            if (rst)
            begin
               ordinaryReg[s] <= RST_ORDINARY;
               pinMapReg[s] <= RST_PINMAP;
               vpMapReg[s] <= RST_VPMAP;
            end
            else
            begin
               if (pinWr)
               begin
                  ordinaryReg[s] <= regBus.wdata[PIN_ORDINARY_BIT];
                  pinMapReg[s] <= regBus.wdata[PIN_W-1:0];
               end
               if (vpWr)
                  vpMapReg[s] <= regBus.wdata[NUM_VP-1:0];
            end
         end
      end
   endgenerate

   // Per-target mode and output stage
   genvar v;
   generate
      for (v = 0; v < NUM_VP; v++)
      begin : g_vp
         wire ctlWr;
         logic [SRC_COUNT-1:0] routed;

         assign ctlWr = wr && ctlSel && (ctlIdx == 5'(v));

         always_ff @(posedge clk_sys)
         begin
            if (rst)
               eicReg[v] <= RST_EIC;
            else if (ctlWr)
               eicReg[v] <= regBus.wdata[CTL_EIC_BIT];
         end

         // Target bit position is the target index v, however many targets exist
         always_comb
         begin
            routed = '0;
            for (int i = 0; i < SRC_COUNT; i++)
               routed[i] = pendReg[i] && enableReg[i] && vpMapReg[i][v];
         end

         // Software-raised sources share this path with wired ones
         gsim_vp_route u_route
         (
            .clk_sys(clk_sys),
            .rst(rst),
            .eicMode(eicReg[v]),
            .active(routed),
            .ordinary(ordinaryReg),
            .pinMap(pinMapReg),
            .intrOut(vpIntr[v]),
            .nmiOut(vpNmi[v])
         );
      end
   endgenerate

   // Register read selection; write-only registers and holes read as zero
   always_comb
   begin
      regBus.rdata = 32'h0000_0000;
      if (addr == CFG_OFS)
         regBus.rdata = cfgWord;
      else if (stateSel)
         regBus.rdata = enWide[laneShift +: 32];
      else if (pendSel)
         regBus.rdata = pendWide[laneShift +: 32];
      else if (pinSel && pinImpl)
         regBus.rdata = {ordinaryReg[pinIdx[5:0]], 25'h000_0000, pinMapReg[pinIdx[5:0]]};
      else if (vpSel && vpImpl)
         regBus.rdata = {8'h00, vpMapReg[vpIdx[5:0]]};
      else if (ctlSel)
         regBus.rdata = {31'h0000_0000, eicReg[ctlIdx]};
      else
         regBus.rdata = 32'h0000_0000;
   end

endmodule

// *** bench/gsim_shared_irq_chk.sv ***
// Port-level checks for the shared interrupt block.
// Assumes one AHB-Lite master with hready looped back from hreadyout.
`timescale 1ns/100ps
module gsim_shared_irq_chk
   import gsim_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // Sources and targets
   input wire logic [SRC_COUNT-1:0] srcIn,
   input wire logic [NUM_VP-1:0][PIN_W-1:0] vpIntr,
   input wire logic [NUM_VP-1:0] vpNmi
);
   logic wrPhase;
   wire takeRd = hsel & htrans[1] & hready & ~hwrite;
   wire takeWr = hsel & htrans[1] & hready & hwrite;
   // Write data phase: the only cycle in which a bus write is committed
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         wrPhase <= 1'b0;
      else if (hready)
         wrPhase <= takeWr;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   chk_bus_okay: assert property (hresp == 1'b0) else $error("error response");
   chk_write_nowait: assert property (takeWr |=> hreadyout) else $error("write stalled");
   chk_read_wait: assert property (takeRd |=> !hreadyout ##1 hreadyout)
      else $error("read wait not one cycle");
   chk_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout) || $past(rst))
      else $error("read data moved outside a read");
   chk_quiet_reset: assert property ($fell(rst) |-> vpIntr == '0 && vpNmi == '0)
      else $error("lines active out of reset");
   // Output register trails pending by one edge, so causes are two samples back
   chk_line_cause: assert property ($changed(vpIntr) |-> $past(wrPhase, 2) ||
      $past(rst) || $past(rst, 2) || ($past(srcIn, 2) & ~$past(srcIn, 3)) != '0)
      else $error("lines changed without cause");
   chk_nmi_cause: assert property ($changed(vpNmi) |-> $past(wrPhase, 2) ||
      $past(rst) || $past(rst, 2) || ($past(srcIn, 2) & ~$past(srcIn, 3)) != '0)
      else $error("nmi changed without cause");
   chk_nmi_drop: assert property ((~vpNmi & $past(vpNmi)) != '0 |->
      $past(wrPhase, 2) || $past(rst) || $past(rst, 2))
      else $error("nmi dropped without a write");
endmodule

bind gsim_shared_irq gsim_shared_irq_chk u_chk
(
   .clk_sys(clk_sys),
   .rst(rst),
   .hsel(hsel),
   .htrans(htrans),
   .hwrite(hwrite),
   .hready(hready),
   .hreadyout(hreadyout),
   .hresp(hresp),
   .hrdata(hrdata),
   .srcIn(srcIn),
   .vpIntr(vpIntr),
   .vpNmi(vpNmi)
);

// *** bench/gsim_vp_model.sv ***
// Core side of the target lines: each target samples its lines once per clock.
// Assumes cores run on clk_sys; nothing flows back into the block.
`timescale 1ns/100ps
module gsim_vp_model
   import gsim_pkg::*;
(
   // Clock
   input wire logic clk_sys,
   // Lines from the controller
   input wire logic [NUM_VP-1:0][PIN_W-1:0] vpIntr,
   input wire logic [NUM_VP-1:0] vpNmi,
   // What the targets observed
   output logic [NUM_VP-1:0][PIN_W-1:0] seenIntr,
   output logic [NUM_VP-1:0] seenNmi
);
   always @(posedge clk_sys)
   begin
      seenIntr <= vpIntr;
      seenNmi <= vpNmi;
   end
endmodule

// *** bench/test_shared_interrupt_mask_route_ipi.sv ***
// Self-checking bench: AHB-Lite master, source drive, read checks via a queue.
// Assumes one master; hready is looped back from hreadyout.
`timescale 1ns/100ps
`define CHK(nm, ex, gt) \
   check_count++; \
   if ((gt) !== (ex)) \
   begin \
      $display("mismatch %s exp %0h got %0h", nm, ex, gt); \
      mismatches++; \
   end
module test_shared_interrupt_mask_route_ipi
   import gsim_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [SRC_COUNT-1:0] srcIn = '0;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic [NUM_VP-1:0][PIN_W-1:0] vpIntr, seenIntr, expIntr;
   logic [NUM_VP-1:0] vpNmi, seenNmi, expNmi;
   logic [31:0] expQ[$];
   logic [31:0] seed = 32'h0000_8E39;
   logic [31:0] r0, r1, m, rdExp;
   logic [5:0] pv[3] = '{6'h00, 6'h3E, 6'h3F};
   logic [5:0] lv[3] = '{6'h01, 6'h3F, 6'h3F};
   logic rdData = 1'b0;
   int mismatches = 0;
   int check_count = 0;
   always #5 clk_sys = ~clk_sys;
   gsim_shared_irq DUT
   (
      .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .srcIn(srcIn),
      .vpIntr(vpIntr), .vpNmi(vpNmi)
   );
   gsim_vp_model u_vp
   (
      .clk_sys(clk_sys), .vpIntr(vpIntr), .vpNmi(vpNmi),
      .seenIntr(seenIntr), .seenNmi(seenNmi)
   );
   // Read data is due in the first ready cycle after a read address phase
   always @(posedge clk_sys)
   begin
      if (rdData && hreadyout === 1'b1)
      begin
         rdExp = expQ.pop_front();
         `CHK("hrdata", rdExp, hrdata)
      end
      if (hreadyout === 1'b1)
         rdData <= hsel & htrans[1] & ~hwrite;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic tally_and_finish();
      if (mismatches == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic wait_ready();
      int n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1)
      begin
         mismatches++;
         tally_and_finish();
      end
   endtask
   // Idle cycle first so no strobe is assigned twice in one time step
   task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {16'h0000, a};
      hwrite <= wr;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_ready();
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      expQ.push_back(e);
      xfer(1'b0, a, 32'h0000_0000);
   endtask
   // Targets see a committed change two edges later
   task automatic lines(input int lag);
      repeat (lag) @(posedge clk_sys);
      #1;
      `CHK("seenIntr", expIntr, seenIntr)
      `CHK("seenNmi", expNmi, seenNmi)
   endtask
   initial
   begin
      expIntr = '0;
      expNmi = '0;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      rd(CFG_OFS, 32'h0000_0040);
      rd(16'h0100, 32'h0000_0000);
      rd(ENSET_BASE, 32'h0000_0000);
      r0 = xs();
      r1 = xs();
      m = xs();
      wr(ENSET_BASE, r0);
      wr(ENSET_BASE + 16'h0004, r1);
      wr(ENSET_BASE + 16'h0008, 32'hFFFF_FFFF);
      wr(DISABLE_BASE, m);
      wr(DISABLE_BASE + 16'h0004, 32'h0000_0000);
      wr(ENSET_BASE, 32'h0000_0000);
      rd(ENSTATE_BASE, r0 & ~m);
      rd(ENSTATE_BASE + 16'h0004, r1);
      rd(ENSTATE_BASE + 16'h0008, 32'h0000_0000);
      wr(DISABLE_BASE, 32'hFFFF_FFFF);
      wr(DISABLE_BASE + 16'h0004, 32'hFFFF_FFFF);
      rd(ENSTATE_BASE + 16'h0004, 32'h0000_0000);
      // Source 40 as an inter-processor interrupt to core 1 target 1, level mode
      wr(16'h05A0, 32'h8000_000E);
      wr(16'h2500, 32'h0000_0020);
      wr(16'h4014, 32'h0000_0001);
      wr(ENSET_BASE + 16'h0004, 32'h0000_0100);
      lines(2);
      wr(WEDGE_OFS, 32'h8000_0028);
      expIntr[5] = 6'h0F;
      lines(2);
      rd(PEND_BASE + 16'h0004, 32'h0000_0100);
      for (int i = 0; i < 3; i++)
      begin
         wr(16'h05A0, 32'h8000_0000 | 32'(pv[i]));
         expIntr[5] = lv[i];
         lines(2);
      end
      // Second target left in pin mode sees the same source on one line
      wr(16'h05A0, 32'h8000_0002);
      wr(16'h2500, 32'h0010_0020);
      expIntr[5] = 6'h03;
      expIntr[20] = 6'h04;
      lines(2);
      wr(16'h05A0, 32'h0000_0002);
      expIntr = '0;
      expNmi[5] = 1'b1;
      expNmi[20] = 1'b1;
      lines(2);
      wr(WEDGE_OFS, 32'h0000_0028);
      expNmi = '0;
      lines(2);
      rd(PEND_BASE + 16'h0004, 32'h0000_0000);
      wr(WEDGE_OFS, 32'h8000_0050);
      rd(PEND_BASE + 16'h0008, 32'h0000_0000);
      // Hardware event on source 3, pin mode on core 0 target 0
      wr(16'h050C, 32'h8000_0000);
      wr(16'h2060, 32'h0000_0001);
      wr(ENSET_BASE, 32'h0000_0008);
      @(posedge clk_sys);
      srcIn[3] <= 1'b1;
      expIntr[0] = 6'h01;
      lines(3);
      rd(PEND_BASE, 32'h0000_0008);
      for (int p = 1; p < 7; p++)
      begin
         wr(16'h050C, 32'h8000_0000 | 32'(p));
         expIntr[0] = (p < 6) ? 6'(1 << p) : 6'h00;
         lines(2);
      end
      // Disabled sources go pending but stay off the lines
      r0 = xs();
      @(posedge clk_sys);
      srcIn[63:48] <= r0[15:0];
      lines(3);
      rd(PEND_BASE + 16'h0004, {r0[15:0], 16'h0000});
      wr(16'h050C, 32'h8000_0001);
      wr(DISABLE_BASE, 32'h0000_0008);
      expIntr[0] = 6'h00;
      lines(2);
      repeat (3) @(posedge clk_sys);
      tally_and_finish();
   end
endmodule
